/* File: logic/ssp_defs.svh */
// Constants of the serial peripheral port: field positions, reset values and counts.
// Behaviour
// - Master data write starts clock, shifts eight bits.
// - Master stops clock after byte, sets complete.
// - Complete flag with enable requests an interrupt.
// - Full duplex exchange, master generates the clock.
// - Master continues with next write or ends.
// - Unselected slave idles, MISO released, ignores clock.
// - Slave loads data while unselected, shifts later.
// - Slave sets complete flag after full byte.
// - Slave accepts new transmit data before reading.
// - Last received byte kept in receive buffer.
// - Transmit single buffered, no write during shift.
// - Unread received byte overwritten by next byte.
// - Enabled role forces pin directions as tabled.
// - Selectable least or most significant first.
// - Seven master rates, fastest half system clock.
// - Write during transfer sets write collision flag.
// - Slave deselect resets logic, drops partial bits.
// - Master with low select input becomes slave.
// - Clock polarity and phase select sample edge.
// - Rate code picks divider, slave ignores it.
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ****************************************************************************
// Control register fields
// ****************************************************************************
`define SSP_CTRL_IRQEN 7
`define SSP_CTRL_EN 6
`define SSP_CTRL_LSBF 5
`define SSP_CTRL_MASTER_SELECT 4
`define SSP_CTRL_CLOCK_IDLE_POLARITY 3
`define SSP_CTRL_CLOCK_SAMPLE_PHASE 2
`define SSP_CTRL_RATE_HI 1
`define SSP_CTRL_RATE_LO 0
`define SSP_CTRL_RST 8'h00
`define SSP_BYTE_RST 8'h00

// ****************************************************************************
// Counts
// ****************************************************************************
`define SSP_CNT_ZERO 4'h0
`define SSP_CNT_ONE 4'h1
`define SSP_BITS_LAST 4'h7
`define SSP_BITS_FULL 4'h8
`define SSP_TOG_ZERO 5'h00
`define SSP_TOG_ONE 5'h01
`define SSP_TOG_FULL 5'h10
`define SSP_DIV_ZERO 7'h00
`define SSP_DIV_ONE 7'h01

// Half periods of the master clock in system cycles, indexed by {double, rate}.
`define SSP_HALF_DIV4 7'h02
`define SSP_HALF_DIV16 7'h08
`define SSP_HALF_DIV64 7'h20
`define SSP_HALF_DIV128 7'h40
`define SSP_HALF_DIV2 7'h01
`define SSP_HALF_DIV8 7'h04
`define SSP_HALF_DIV32 7'h10

`endif

/* File: logic/ssp_pkg.sv */
// Types shared by the serial peripheral port modules.
package ssp_pkg;
  typedef logic [7:0] ssp_byte_t;
  typedef logic [3:0] ssp_cnt_t;
  typedef enum logic [1:0]
  {
    SSP_IDLE = 2'h0,
    SSP_SHIFT = 2'h1,
    SSP_END = 2'h3
  } ssp_state_e;
endpackage : ssp_pkg

/* File: logic/ssp_clk_if.sv */
// Link between the port core and its master clock generator.
`timescale 1ns/1ps
`default_nettype none
interface ssp_clk_if;
  logic run;
  logic clock_idle_polarity;
  logic dbl;
  logic [1:0] rate;
  logic sck;
  modport gen (input run, input clock_idle_polarity, input dbl, input rate, output sck);
  modport core (output run, output clock_idle_polarity, output dbl, output rate, input sck);
endinterface : ssp_clk_if
`default_nettype wire

/* File: logic/ssp_clkgen.sv */
// Master serial clock generator: divides the system clock and emits one byte of edges.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"
module ssp_clkgen
(
  input wire logic clk_sys,
  input wire logic nrst,
  ssp_clk_if.gen cif
);
  logic [6:0] div_ff;
  logic [6:0] nxt_div;
  logic [4:0] tog_ff;
  logic [4:0] nxt_tog;
  logic sck_ff;
  logic nxt_sck;
  logic [6:0] half;

  // ****************************************************************************
  // Divider selection
  // ****************************************************************************
  // Half period in system cycles; the double speed setting halves every divider.
  always_comb
  begin
    case ({cif.dbl, cif.rate})
      3'h0: half = `SSP_HALF_DIV4;
      3'h1: half = `SSP_HALF_DIV16;
      3'h2: half = `SSP_HALF_DIV64;
      3'h3: half = `SSP_HALF_DIV128;
      3'h4: half = `SSP_HALF_DIV2;
      3'h5: half = `SSP_HALF_DIV8;
      3'h6: half = `SSP_HALF_DIV32;
      default: half = `SSP_HALF_DIV64;
    endcase
  end

  // ****************************************************************************
  // Edge generation
  // ****************************************************************************
  // Counting toggles here stops the clock on the sixteenth edge even at the
  // fastest rate, where the core sees completion a cycle too late to stop it.
  always_comb
  begin
    nxt_div = div_ff;
    nxt_tog = tog_ff;
    nxt_sck = sck_ff;
    if (!cif.run)
    begin
      nxt_div = `SSP_DIV_ZERO;
      nxt_tog = `SSP_TOG_ZERO;
      nxt_sck = cif.clock_idle_polarity;
    end
    else if (tog_ff != `SSP_TOG_FULL)
    begin
      if (div_ff == half - `SSP_DIV_ONE)
      begin
        nxt_div = `SSP_DIV_ZERO;
        nxt_sck = ~sck_ff;
        nxt_tog = tog_ff + `SSP_TOG_ONE;
      end
      else
      begin
        nxt_div = div_ff + `SSP_DIV_ONE;
      end
    end
  end

  // Registers of the generator.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      div_ff <= `SSP_DIV_ZERO;
      tog_ff <= `SSP_TOG_ZERO;
      sck_ff <= 1'b0;
    end
    else
    begin
      div_ff <= nxt_div;
      tog_ff <= nxt_tog;
      sck_ff <= nxt_sck;
    end
  end

  assign cif.sck = sck_ff;
endmodule : ssp_clkgen
`default_nettype wire

/* File: logic/ssp_top.sv */
// Serial peripheral port core: control, shift engine, flags and pin direction control.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"
module ssp_top
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CTRL_WR,
  input wire logic [7:0] CTRL_WDATA,
  output logic [7:0] CTRL_RDATA,
  input wire logic DOUBLE_SPEED,
  input wire logic DATA_WR,
  input wire logic [7:0] DATA_WDATA,
  output logic [7:0] RX_DATA,
  input wire logic FLAG_CLR,
  output logic TC_FLAG,
  output logic WRITE_COLLISION_FLAG_FLAG,
  output logic IRQ,
  input wire logic USER_MOSI_OE,
  input wire logic USER_MISO_OE,
  input wire logic USER_SCK_OE,
  input wire logic USER_SS_OE,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  input wire logic SS_N_I,
  output logic SS_OE
);
  ssp_pkg::ssp_state_e state_ff;
  ssp_pkg::ssp_state_e nxt_state;
  ssp_pkg::ssp_byte_t ctrl_ff;
  ssp_pkg::ssp_byte_t nxt_ctrl;
  ssp_pkg::ssp_byte_t shreg_ff;
  ssp_pkg::ssp_byte_t nxt_shreg;
  ssp_pkg::ssp_byte_t rxbuf_ff;
  ssp_pkg::ssp_byte_t nxt_rxbuf;
  ssp_pkg::ssp_cnt_t cnt_ff;
  ssp_pkg::ssp_cnt_t nxt_cnt;
  logic out_ff;
  logic nxt_out;
  logic lvl_prev_ff;
  logic tc_ff;
  logic nxt_tc;
  logic write_collision_flag_ff;
  logic nxt_write_collision_flag;
  logic irq_ff;
  logic sck_o_ff;
  logic mosi_oe_ff;
  logic nxt_mosi_oe;
  logic miso_oe_ff;
  logic nxt_miso_oe;
  logic sck_oe_ff;
  logic nxt_sck_oe;
  logic ss_oe_ff;
  logic nxt_ss_oe;
  logic en;
  logic master_select;
  logic clock_idle_polarity;
  logic clock_sample_phase;
  logic lsbf;
  logic lvl;
  logic lead;
  logic trail;
  logic sample;
  logic setup;
  logic sin;
  logic busy;
  logic mode_fault;
  logic slv_sel;
  logic slv_load;

  ssp_clk_if cif ();

  // ****************************************************************************
  // Master clock generator
  // ****************************************************************************
  ssp_clkgen u_clkgen
  (
    .clk_sys(CLK_SYS),
    .nrst(NRST),
    .cif(cif.gen)
  );

  // Generator runs only for a master transfer in progress.
  assign cif.run = en & master_select & (state_ff == ssp_pkg::SSP_SHIFT);
  assign cif.clock_idle_polarity = clock_idle_polarity;
  assign cif.dbl = DOUBLE_SPEED;
  assign cif.rate = ctrl_ff[`SSP_CTRL_RATE_HI:`SSP_CTRL_RATE_LO];

  // ****************************************************************************
  // Decode of control and edges
  // ****************************************************************************
  // Control fields and the working clock level, from the generator or the pin.
  assign en = ctrl_ff[`SSP_CTRL_EN];
  assign master_select = ctrl_ff[`SSP_CTRL_MASTER_SELECT];
  assign clock_idle_polarity = ctrl_ff[`SSP_CTRL_CLOCK_IDLE_POLARITY];
  assign clock_sample_phase = ctrl_ff[`SSP_CTRL_CLOCK_SAMPLE_PHASE];
  assign lsbf = ctrl_ff[`SSP_CTRL_LSBF];
  assign lvl = master_select ? cif.sck : SCK_I;
  assign lead = (lvl != lvl_prev_ff) & (lvl != clock_idle_polarity);
  assign trail = (lvl != lvl_prev_ff) & (lvl == clock_idle_polarity);
  assign sample = clock_sample_phase ? trail : lead;
  assign setup = clock_sample_phase ? lead : trail;
  assign sin = master_select ? MISO_I : MOSI_I;
  assign busy = state_ff != ssp_pkg::SSP_IDLE;
  // A low select on an input pin means another master has taken the bus.
  assign mode_fault = en & master_select & ~USER_SS_OE & ~SS_N_I;
  assign slv_sel = en & ~master_select & ~SS_N_I;
  // A selected slave between bytes takes a new transmit byte until its first sample edge.
  assign slv_load = ~master_select & DATA_WR & (state_ff == ssp_pkg::SSP_SHIFT) & (cnt_ff == `SSP_CNT_ZERO) & ~sample;

  // ****************************************************************************
  // Shift engine
  // ****************************************************************************
  // Sampled bits enter at one end while the outgoing bit leaves the other, so one
  // register serves both directions of the full duplex exchange.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_shreg = shreg_ff;
    nxt_cnt = cnt_ff;
    nxt_out = lsbf ? shreg_ff[0] : shreg_ff[7];
    nxt_rxbuf = rxbuf_ff;
    nxt_ctrl = CTRL_WR ? CTRL_WDATA : ctrl_ff;
    nxt_tc = tc_ff & ~FLAG_CLR;
    nxt_write_collision_flag = write_collision_flag_ff & ~FLAG_CLR;
    if (!en)
    begin
      nxt_state = ssp_pkg::SSP_IDLE;
      nxt_cnt = `SSP_CNT_ZERO;
    end
    else if (mode_fault)
    begin
      nxt_ctrl[`SSP_CTRL_MASTER_SELECT] = 1'b0;
      nxt_tc = 1'b1;
      nxt_state = ssp_pkg::SSP_IDLE;
      nxt_cnt = `SSP_CNT_ZERO;
    end
    else
    begin
      case (state_ff)
        ssp_pkg::SSP_IDLE:
        begin
          if (DATA_WR)
          begin
            nxt_shreg = DATA_WDATA;
            nxt_out = lsbf ? DATA_WDATA[0] : DATA_WDATA[7];
          end
          nxt_cnt = `SSP_CNT_ZERO;
          if (master_select && DATA_WR)
          begin
            nxt_state = ssp_pkg::SSP_SHIFT;
          end
          else if (!master_select && slv_sel && !DATA_WR)
          begin
            nxt_state = ssp_pkg::SSP_SHIFT;
          end
        end
        ssp_pkg::SSP_SHIFT:
        begin
          nxt_out = out_ff;
          if (!master_select && SS_N_I)
          begin
            nxt_state = ssp_pkg::SSP_IDLE;
            nxt_cnt = `SSP_CNT_ZERO;
          end
          else if (slv_load)
          begin
            nxt_shreg = DATA_WDATA;
            nxt_out = lsbf ? DATA_WDATA[0] : DATA_WDATA[7];
          end
          else if (sample)
          begin
            nxt_shreg = lsbf ? {sin, shreg_ff[7:1]} : {shreg_ff[6:0], sin};
            nxt_cnt = cnt_ff + `SSP_CNT_ONE;
            if (cnt_ff == `SSP_BITS_LAST && (!master_select || clock_sample_phase))
            begin
              nxt_state = ssp_pkg::SSP_END;
            end
          end
          else if (setup)
          begin
            nxt_out = lsbf ? shreg_ff[0] : shreg_ff[7];
            if (master_select && cnt_ff == `SSP_BITS_FULL)
            begin
              nxt_state = ssp_pkg::SSP_END;
            end
          end
        end
        ssp_pkg::SSP_END:
        begin
          nxt_out = out_ff;
          nxt_rxbuf = shreg_ff;
          nxt_tc = 1'b1;
          nxt_cnt = `SSP_CNT_ZERO;
          nxt_state = ssp_pkg::SSP_IDLE;
        end
        default:
        begin
          nxt_state = ssp_pkg::SSP_IDLE;
          nxt_cnt = `SSP_CNT_ZERO;
        end
      endcase
      // Writes during a transfer are dropped; the data register holds one byte.
      if (DATA_WR && busy && !slv_load)
      begin
        nxt_write_collision_flag = 1'b1;
      end
    end
  end

  // ****************************************************************************
  // Pin direction overrides
  // ****************************************************************************
  // A disabled port hands every direction back to the user setting.
  always_comb
  begin
    nxt_mosi_oe = USER_MOSI_OE;
    nxt_miso_oe = USER_MISO_OE;
    nxt_sck_oe = USER_SCK_OE;
    nxt_ss_oe = USER_SS_OE;
    if (en && master_select && !mode_fault)
    begin
      nxt_miso_oe = 1'b0;
    end
    else if (en)
    begin
      nxt_mosi_oe = 1'b0;
      nxt_sck_oe = 1'b0;
      nxt_ss_oe = 1'b0;
      nxt_miso_oe = USER_MISO_OE & ~SS_N_I;
    end
  end

  // ****************************************************************************
  // Registers
  // ****************************************************************************
  // All state registers, reset synchronously to their idle values.
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      state_ff <= ssp_pkg::SSP_IDLE;
      ctrl_ff <= `SSP_CTRL_RST;
      shreg_ff <= `SSP_BYTE_RST;
      rxbuf_ff <= `SSP_BYTE_RST;
      cnt_ff <= `SSP_CNT_ZERO;
      out_ff <= 1'b0;
      lvl_prev_ff <= 1'b0;
      tc_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
      irq_ff <= 1'b0;
      sck_o_ff <= 1'b0;
      mosi_oe_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
      sck_oe_ff <= 1'b0;
      ss_oe_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      ctrl_ff <= nxt_ctrl;
      shreg_ff <= nxt_shreg;
      rxbuf_ff <= nxt_rxbuf;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
      lvl_prev_ff <= lvl;
      tc_ff <= nxt_tc;
      write_collision_flag_ff <= nxt_write_collision_flag;
      irq_ff <= nxt_tc & nxt_ctrl[`SSP_CTRL_IRQEN];
      sck_o_ff <= cif.sck;
      mosi_oe_ff <= nxt_mosi_oe;
      miso_oe_ff <= nxt_miso_oe;
      sck_oe_ff <= nxt_sck_oe;
      ss_oe_ff <= nxt_ss_oe;
    end
  end

  // Outputs, each straight from a register.
  assign CTRL_RDATA = ctrl_ff;
  assign RX_DATA = rxbuf_ff;
  assign TC_FLAG = tc_ff;
  assign WRITE_COLLISION_FLAG_FLAG = write_collision_flag_ff;
  assign IRQ = irq_ff;
  assign MOSI_O = out_ff;
  assign MISO_O = out_ff;
  assign SCK_O = sck_o_ff;
  assign MOSI_OE = mosi_oe_ff;
  assign MISO_OE = miso_oe_ff;
  assign SCK_OE = sck_oe_ff;
  assign SS_OE = ss_oe_ff;

  // ****************************************************************************
  // Assertions
  // ****************************************************************************
  sequence s_master_select_load;
    en && master_select && !mode_fault && state_ff == ssp_pkg::SSP_IDLE && DATA_WR;
  endsequence

  sequence s_byte_end;
    en && !mode_fault && state_ff == ssp_pkg::SSP_END;
  endsequence

  property p_start;
    @(posedge CLK_SYS) disable iff (!NRST)
    s_master_select_load |=> state_ff == ssp_pkg::SSP_SHIFT ##1 cif.run;
  endproperty
  a_start: assert property (p_start) else $error("master write did not start");

  property p_finish;
    @(posedge CLK_SYS) disable iff (!NRST)
    s_byte_end |=> TC_FLAG && RX_DATA == $past(shreg_ff) && !busy;
  endproperty
  a_finish: assert property (p_finish) else $error("byte end not flagged");

  property p_irq;
    @(posedge CLK_SYS) disable iff (!NRST)
    (tc_ff && ctrl_ff[`SSP_CTRL_IRQEN] && !CTRL_WR && !FLAG_CLR) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_idle_slave;
    @(posedge CLK_SYS) disable iff (!NRST)
    (en && !master_select && SS_N_I && !CTRL_WR) |=> !MISO_OE && state_ff == ssp_pkg::SSP_IDLE;
  endproperty
  a_idle_slave: assert property (p_idle_slave) else $error("slave active while deselected");

  property p_write_collision_flag;
    @(posedge CLK_SYS) disable iff (!NRST)
    (en && !mode_fault && busy && DATA_WR && !slv_load) |=> WRITE_COLLISION_FLAG_FLAG;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

  property p_fault;
    @(posedge CLK_SYS) disable iff (!NRST)
    (mode_fault && !CTRL_WR) |=> !CTRL_RDATA[`SSP_CTRL_MASTER_SELECT] && TC_FLAG && !busy;
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault not handled");

  property p_miso_in;
    @(posedge CLK_SYS) disable iff (!NRST)
    (en && master_select && !mode_fault) |=> !MISO_OE;
  endproperty
  a_miso_in: assert property (p_miso_in) else $error("master drove data in pin");

  property p_off;
    @(posedge CLK_SYS) disable iff (!NRST)
    (!en && !CTRL_WR) |=> !busy && MOSI_OE == $past(USER_MOSI_OE) ##1 !busy;
  endproperty
  a_off: assert property (p_off) else $error("disabled port still active");

  property p_sck_idle;
    @(posedge CLK_SYS) disable iff (!NRST)
    (en && master_select && !busy && !CTRL_WR) [*3] |=> SCK_O == clock_idle_polarity;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("idle clock level wrong");
endmodule : ssp_top
`default_nettype wire

/* File: bench/ssp_peer.sv */
// Behavioural far-side slave that exchanges one byte per select frame.
`timescale 1ns/1ps
`default_nettype none
module ssp_peer
(
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic [1:0] mode,
  input wire logic lsbf,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  // ****************************************************************************
  // Shift engine
  // ****************************************************************************
  int oi = 0;
  initial miso = 1'b0;
  initial rx = 8'h00;

  // Shows the next transmit bit; past the last bit the line toggles, as it is not held.
  task automatic put();
    if (oi < 8) miso <= #1 lsbf ? tx[oi] : tx[7 - oi];
    else miso <= #1 ~miso;
    oi++;
  endtask : put

  // A select fall restarts the frame; phase zero shows its first bit at once.
  always @(negedge ss_n)
  begin
    oi = 0;
    if (!mode[0]) put();
  end

  // A released line gives the inverse of its last level, so no stale copy can pass.
  always @(posedge ss_n)
    miso <= #1 ~miso;

  // Leading edge samples when phase is zero, the trailing one otherwise.
  always @(sck)
  begin
    if (!ss_n)
    begin
      if ((sck != mode[1]) == !mode[0])
        rx = lsbf ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      else
        put();
    end
  end
endmodule : ssp_peer
`default_nettype wire

/* File: bench/serial_peripheral_port_tb_top.sv */
// Self-checking bench: master bytes against the far-side model, slave frames driven here.
`timescale 1ns/1ps
`default_nettype none
module serial_peripheral_port_tb_top;
  // ****************************************************************************
  // Stimulus, wiring and checks
  // ****************************************************************************
  logic clk = 0, nrst = 0, ctrl_wr = 0, dbl = 0, data_wr = 0, flag_clr = 0;
  logic [7:0] ctrl_wdata = 8'h00, data_wdata = 8'h00;
  logic [3:0] user_oe = 4'hF;
  logic tb_sck = 0, tb_mosi = 0, ss_n = 1, peer_off = 0, plsbf = 0;
  logic [1:0] pmode = 2'b00, smode = 2'b00;
  logic [7:0] ptx = 8'h00, ctrl_rdata, rx_data, peer_rx;
  logic tc, write_collision_flag, irq, mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe, ss_oe, peer_miso;
  logic sck_w, mosi_w, miso_w;
  int failures = 0, comparisons = 0;

  // Each line is driven by whoever has its enable up.
  assign sck_w = sck_oe ? sck_o : tb_sck;
  assign mosi_w = mosi_oe ? mosi_o : tb_mosi;
  assign miso_w = miso_oe ? miso_o : peer_miso;

  initial forever #4 clk = ~clk;

  ssp_top dut (.CLK_SYS(clk), .NRST(nrst), .CTRL_WR(ctrl_wr), .CTRL_WDATA(ctrl_wdata),
    .CTRL_RDATA(ctrl_rdata), .DOUBLE_SPEED(dbl), .DATA_WR(data_wr), .DATA_WDATA(data_wdata),
    .RX_DATA(rx_data), .FLAG_CLR(flag_clr), .TC_FLAG(tc), .WRITE_COLLISION_FLAG_FLAG(write_collision_flag), .IRQ(irq),
    .USER_MOSI_OE(user_oe[3]), .USER_MISO_OE(user_oe[2]), .USER_SCK_OE(user_oe[1]),
    .USER_SS_OE(user_oe[0]), .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe),
    .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe), .SCK_I(sck_w), .SCK_O(sck_o),
    .SCK_OE(sck_oe), .SS_N_I(ss_n), .SS_OE(ss_oe));

  ssp_peer peer (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_n | peer_off), .mode(pmode),
    .lsbf(plsbf), .tx(ptx), .miso(peer_miso), .rx(peer_rx));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask : chk_bit

  // Enables packed as mosi, miso, sck, select.
  task automatic chk_oe(input logic [7:0] exp);
    chk_byte({4'h0, mosi_oe, miso_oe, sck_oe, ss_oe}, exp, "pin enables");
  endtask : chk_oe

  task automatic wr_ctrl(input logic [7:0] v);
    ctrl_wdata = v;
    ctrl_wr = 1;
    tick(1);
    ctrl_wr = 0;
    tick(1);
  endtask : wr_ctrl

  task automatic wr_data(input logic [7:0] v);
    data_wdata = v;
    data_wr = 1;
    tick(1);
    data_wr = 0;
    tick(1);
  endtask : wr_data

  task automatic clr();
    flag_clr = 1;
    tick(1);
    flag_clr = 0;
    tick(1);
  endtask : clr

  // Half periods in system cycles, indexed by double speed and rate code.
  function automatic int half(input logic d, input logic [1:0] r);
    int tbl[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
    return tbl[{d, r}];
  endfunction : half

  // Acts as an external master, most significant bit first, four cycles per clock phase.
  task automatic slv_byte(input logic [7:0] d, input int nb, output logic [7:0] got);
    got = 8'h00;
    for (int i = 0; i < nb; i++)
    begin
      if (!smode[0]) tb_mosi = d[7 - i];
      tick(4);
      if (!smode[0]) got[7 - i] = miso_w;
      tb_sck = ~smode[1];
      if (smode[0]) tb_mosi = d[7 - i];
      tick(4);
      if (smode[0]) got[7 - i] = miso_w;
      tb_sck = smode[1];
    end
    tick(4);
  endtask : slv_byte

  task automatic end_sim();
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // Main sequence: reset, master sweep, mode fault, slave frames, disabled port.
  initial
  begin
    logic [7:0] t, pt, got;
    logic [3:0] cfg;
    int n;
    void'($urandom(87003));
    tick(16);
    nrst = 1;
    chk_byte(ctrl_rdata, 8'h00, "control reset");
    chk_byte(rx_data, 8'h00, "receive reset");
    chk_bit(tc | write_collision_flag | irq, 1'b0, "flags reset");
    for (int i = 0; i < 16; i++)
    begin
      t = $urandom;
      pt = $urandom;
      cfg = $urandom;
      dbl = i[2];
      pmode = cfg[1:0];
      plsbf = cfg[3];
      ptx = pt;
      wr_ctrl({cfg[2], 1'b1, cfg[3], 1'b1, cfg[1:0], i[1:0]});
      chk_byte(ctrl_rdata, {cfg[2], 1'b1, cfg[3], 1'b1, cfg[1:0], i[1:0]}, "control");
      chk_oe(8'h0B);
      tick(2);
      ss_n = 0;
      tick(2);
      data_wdata = t;
      data_wr = 1;
      n = 0;
      while (tc !== 1'b1 && n < 3000)
      begin
        tick(1);
        n++;
        data_wdata = ~t;
        data_wr = (i == 5 && n == 3);
      end
      chk_bit(n >= 16 * half(i[2], i[1:0]) && n <= 16 * half(i[2], i[1:0]) + 6, 1'b1, "byte time");
      chk_byte(rx_data, pt, "master receive");
      chk_byte(peer_rx, t, "far side receive");
      chk_bit(irq, cfg[2], "interrupt");
      chk_bit(write_collision_flag, i == 5, "collision");
      chk_bit(sck_o, cfg[1], "clock idle");
      ss_n = 1;
      clr();
      chk_bit(tc | irq, 1'b0, "flag clear");
    end
    user_oe = 4'b1110;
    peer_off = 1;
    wr_ctrl(8'hD0);
    ss_n = 0;
    tick(3);
    chk_byte(ctrl_rdata, 8'hC0, "mode fault control");
    chk_bit(tc & irq, 1'b1, "mode fault flag");
    chk_oe(8'h04);
    ss_n = 1;
    user_oe = 4'hF;
    clr();
    for (int m = 0; m < 4; m++)
    begin
      smode = m[1:0];
      tb_sck = m[1];
      t = $urandom;
      pt = $urandom;
      wr_ctrl({4'hC, m[1:0], 2'b11});
      wr_data(pt);
      chk_oe(8'h00);
      ss_n = 0;
      tick(2);
      chk_oe(8'h04);
      slv_byte(t, 8, got);
      chk_byte(got, pt, "slave transmit");
      chk_bit(tc & irq, 1'b1, "slave complete");
      chk_byte(rx_data, t, "slave receive");
      clr();
      wr_data(~pt);
      slv_byte(~t, 8, got);
      chk_byte(got, ~pt, "slave second transmit");
      chk_byte(rx_data, ~t, "slave overwrite");
      ss_n = 1;
      tb_mosi = ~tb_mosi;
      clr();
      ss_n = 0;
      tick(2);
      slv_byte(pt, 4, got);
      ss_n = 1;
      tick(4);
      chk_bit(tc, 1'b0, "aborted byte");
      ss_n = 0;
      tick(2);
      slv_byte(t, 8, got);
      chk_byte(rx_data, t, "byte after abort");
      ss_n = 1;
      clr();
    end
    user_oe = 4'b1001;
    wr_ctrl(8'h00);
    chk_oe(8'h09);
    wr_data(8'hA5);
    ss_n = 0;
    slv_byte(8'h3C, 8, got);
    chk_bit(tc | write_collision_flag, 1'b0, "disabled port");
    ss_n = 1;
    end_sim();
  end

  // Watchdog sized well beyond the longest sweep.
  initial
  begin
    #800000;
    failures++;
    end_sim();
  end
endmodule : serial_peripheral_port_tb_top
`default_nettype wire
